// >>> design/dsp_map.vh
// constants for the dual serial host port: frame layout, target address, codes
// assumes it is included by the one design file of the port
`ifndef DSP_MAP_VH
`define DSP_MAP_VH

// -------------------------------------------------------------
// spi frame layout
// -------------------------------------------------------------
`define DSP_FRAME_BITS 5'h18
`define DSP_FRAME_LAST 5'h17
`define DSP_RW_BIT 23
`define DSP_ADDR_HI 22
`define DSP_ADDR_LO 16
`define DSP_DATA_HI 15

// -------------------------------------------------------------
// i2c target address and general call
// -------------------------------------------------------------
`define DSP_I2C_PREFIX 4'h9
`define DSP_I2C_BCAST 7'h47
`define DSP_GC_ADDR 8'h00
`define DSP_GC_RESET 8'h06
`define DSP_BYTE_BITS 4'h8

// -------------------------------------------------------------
// reset values
// -------------------------------------------------------------
`define DSP_WORD_RST 24'h00_0000

`endif

// >>> design/dsp_port.v
// dual serial host port: spi slave and i2c target feeding a register write fifo
// assumes register storage outside; read data answers rd_addr_o combinationally
//
// Summary of operation
// - select low opens frame, high closes it
// - sample serial input on falling clock edges
// - frames shorter than 24 edges are discarded
// - three-wire: keep only the first 24 bits
// - select high: block clock, input; output released
// - serial output disabled after reset
// - first byte is instruction: direction, address
// - bit23 read flag, 22-16 address, 15-0 data
// - reads need serial output enabled
// - read answer comes in the next frame
// - next frame returns flag, address, register data
// - output launch edge chosen by configuration bit
// - daisy chain: multiple of 24 uses last 24
// - only 7-bit target addressing supported
// - same protocol at every i2c bus rate
// - general call 0x06 resets at ack rise
// - ninth clock carries acknowledge, low means ack
// - sda fall with scl high is start
// - data changes only while scl low
// - acknowledge address only when it matches
// - direction bit selects write or read, ack bytes
// - stop releases bus, wait for next start
// - lock onto first protocol seen after reset
// - address prefix 1001, strap sampled first byte
`timescale 1ns/1ps
`include "dsp_map.vh"

module dsp_fifo #(
	parameter W = 23,
	parameter D = 8,
	parameter AW = 3
) (
	// clock and reset
	input wire clk_sys_i,
	input wire reset_i,
	// fill side
	input wire in_valid_i,
	output wire in_ready_o,
	input wire [W-1:0] in_data_i,
	// drain side
	output wire out_valid_o,
	input wire out_ready_i,
	output wire [W-1:0] out_data_o
);
	reg [W-1:0] mem [0:D-1];
	reg [AW-1:0] wp;
	reg [AW-1:0] rp;
	reg [AW:0] cnt;
	wire push;
	wire pop;

	assign in_ready_o = (cnt != D);
	assign out_valid_o = (cnt != 0);
	assign out_data_o = mem[rp];
	assign push = in_valid_i && in_ready_o;
	assign pop = out_valid_o && out_ready_i;

	always @(posedge clk_sys_i)
	begin
		if (push)
			mem[wp] <= in_data_i;
	end

	always @(posedge clk_sys_i)
	begin
		if (reset_i)
		begin
			wp <= 0;
			rp <= 0;
			cnt <= 0;
		end
		else
		begin
			if (push)
				wp <= (wp == D - 1) ? {AW{1'b0}} : wp + 1'b1;
			if (pop)
				rp <= (rp == D - 1) ? {AW{1'b0}} : rp + 1'b1;
			if (push && !pop)
				cnt <= cnt + 1'b1;
			else if (pop && !push)
				cnt <= cnt - 1'b1;
		end
	end
endmodule // dsp_fifo

module dsp_port #(
	parameter FIFO_DEPTH = 8
) (
	// clock and reset
	input wire clk_sys_i,
	input wire reset_i,
	// spi pins
	input wire spi_sclk_i,
	input wire spi_sel_n_i,
	input wire spi_sdi_i,
	output reg spi_sdo_o,
	output wire spi_sdo_oe_o,
	// i2c pins, open drain
	input wire scl_i,
	output wire scl_o,
	output wire scl_oe_o,
	input wire sda_i,
	output wire sda_o,
	output wire sda_oe_o,
	input wire [2:0] address_strap_pin_i,
	// configuration
	input wire serial_out_enable_i,
	input wire out_edge_select_i,
	// register write stream
	output wire wr_valid_o,
	input wire wr_ready_i,
	output wire [6:0] wr_addr_o,
	output wire [15:0] wr_data_o,
	// register read
	output wire [6:0] rd_addr_o,
	input wire [15:0] rd_data_i,
	// status
	output reg sw_reset_o,
	output reg lock_spi_o,
	output reg lock_i2c_o
);
	// -------------------------------------------------------------
	// pin synchronisers
	// -------------------------------------------------------------
	reg [7:0] meta;
	reg [7:0] syn;
	reg [7:0] prv;
	wire [7:0] pins = {address_strap_pin_i, scl_i, sda_i, spi_sel_n_i, spi_sclk_i, spi_sdi_i};

	always @(posedge clk_sys_i)
	begin
		if (reset_i)
		begin
			meta <= 8'hff;
			syn <= 8'hff;
			prv <= 8'hff;
		end
		else
		begin
			meta <= pins;
			syn <= meta;
			prv <= syn;
		end
	end

	wire sdi = syn[0];
	wire sel_lo = !syn[2];
	wire sclk_fall = prv[1] && !syn[1];
	wire sclk_rise = !prv[1] && syn[1];
	wire sel_fall = prv[2] && !syn[2];
	wire sel_rise = !prv[2] && syn[2];
	wire sda = syn[3];
	wire scl = syn[4];
	wire scl_rise = !prv[4] && scl;
	wire scl_fall = prv[4] && !scl;
	wire i2c_start = scl && prv[4] && prv[3] && !sda;
	wire i2c_stop = scl && prv[4] && !prv[3] && sda;

	// -------------------------------------------------------------
	// protocol lock
	// -------------------------------------------------------------
	always @(posedge clk_sys_i)
	begin
		if (reset_i)
		begin
			lock_spi_o <= 1'b0;
			lock_i2c_o <= 1'b0;
		end
		else
		begin
			if (sel_fall && !lock_i2c_o)
				lock_spi_o <= 1'b1;
			if (i2c_start && !lock_spi_o && !sel_lo)
				lock_i2c_o <= 1'b1;
		end
	end
	wire spi_on = !lock_i2c_o;
	wire i2c_on = !lock_spi_o;

	// -------------------------------------------------------------
	// spi receive and commit
	// -------------------------------------------------------------
	reg [23:0] rx_sr;
	reg [23:0] first24;
	reg [4:0] mod24;
	reg got24;
	reg commit;
	reg [23:0] cmd_frame;
	reg [23:0] out_word;
	reg [23:0] tx_sr;
	reg shifted;
	reg [6:0] spi_raddr;
	reg spi_wr;
	wire [23:0] rx_next = {rx_sr[22:0], sdi};
	wire four_wire = serial_out_enable_i;
	// three-wire frames stop at the first 24, daisy chain wants a whole multiple
	wire frame_ok = four_wire ? (got24 && mod24 == 5'h00) : got24;
	wire [23:0] frame = four_wire ? rx_sr : first24;

	always @(posedge clk_sys_i)
	begin
		if (reset_i)
		begin
			rx_sr <= `DSP_WORD_RST;
			first24 <= `DSP_WORD_RST;
			mod24 <= 5'h00;
			got24 <= 1'b0;
			commit <= 1'b0;
			cmd_frame <= `DSP_WORD_RST;
			out_word <= `DSP_WORD_RST;
			spi_raddr <= 7'h00;
			spi_wr <= 1'b0;
		end
		else
		begin
			commit <= 1'b0;
			spi_wr <= 1'b0;
			if (spi_on && sel_fall)
			begin
				mod24 <= 5'h00;
				got24 <= 1'b0;
			end
			else if (spi_on && sel_lo && sclk_fall)
			begin
				rx_sr <= rx_next;
				mod24 <= (mod24 == `DSP_FRAME_LAST) ? 5'h00 : mod24 + 5'h01;
				if (mod24 == `DSP_FRAME_LAST)
				begin
					got24 <= 1'b1;
					if (!got24)
						first24 <= rx_next;
				end
			end
			if (spi_on && sel_rise && frame_ok)
			begin
				commit <= 1'b1;
				cmd_frame <= frame;
				spi_raddr <= frame[`DSP_ADDR_HI:`DSP_ADDR_LO];
				spi_wr <= !frame[`DSP_RW_BIT];
			end
			if (commit)
			begin
				// reads answer in the next frame; writes are echoed
				if (cmd_frame[`DSP_RW_BIT] && four_wire)
					out_word <= {cmd_frame[23:16], rd_data_i};
				else
					out_word <= cmd_frame;
			end
		end
	end

	// -------------------------------------------------------------
	// spi transmit
	// -------------------------------------------------------------
	// bits shifted out are replaced by input bits, so the chain passes data on
	always @(posedge clk_sys_i)
	begin
		if (reset_i)
		begin
			tx_sr <= `DSP_WORD_RST;
			shifted <= 1'b0;
			spi_sdo_o <= 1'b0;
		end
		else
		begin
			if (spi_on && sel_fall)
			begin
				tx_sr <= {out_word[22:0], 1'b0};
				spi_sdo_o <= out_word[23];
				shifted <= 1'b0;
			end
			else if (spi_on && sel_lo)
			begin
				if (sclk_fall)
					shifted <= 1'b1;
				// rising launch waits for the first falling edge to be sampled
				if ((!out_edge_select_i && sclk_fall) || (out_edge_select_i && sclk_rise && shifted))
				begin
					spi_sdo_o <= tx_sr[23];
					tx_sr <= {tx_sr[22:0], sdi};
				end
			end
		end
	end
	assign spi_sdo_oe_o = four_wire && sel_lo && spi_on;

	// -------------------------------------------------------------
	// i2c target
	// -------------------------------------------------------------
	localparam [5:0] ST_IDLE = 6'h01;
	localparam [5:0] ST_ADDR = 6'h02;
	localparam [5:0] ST_ACK = 6'h04;
	localparam [5:0] ST_RX = 6'h08;
	localparam [5:0] ST_TX = 6'h10;
	localparam [5:0] ST_MACK = 6'h20;

	reg [5:0] st;
	reg [3:0] bitc;
	reg [7:0] sh;
	reg [2:0] strap;
	reg rw;
	reg gc;
	reg gc_arm;
	reg ack_drv;
	reg mack_ok;
	reg [1:0] bidx;
	reg [6:0] i2c_raddr;
	reg [7:0] msdb;
	reg i2c_wr;
	reg [22:0] i2c_word;
	wire [7:0] rx_byte = {sh[6:0], sda};

	always @(posedge clk_sys_i)
	begin
		if (reset_i)
		begin
			st <= ST_IDLE;
			bitc <= 4'h0;
			sh <= 8'h00;
			strap <= 3'h0;
			rw <= 1'b0;
			gc <= 1'b0;
			gc_arm <= 1'b0;
			ack_drv <= 1'b0;
			mack_ok <= 1'b0;
			bidx <= 2'h0;
			i2c_raddr <= 7'h00;
			msdb <= 8'h00;
			i2c_wr <= 1'b0;
			i2c_word <= 23'h00_0000;
			sw_reset_o <= 1'b0;
		end
		else
		begin
			i2c_wr <= 1'b0;
			sw_reset_o <= 1'b0;
			if (!i2c_on)
				st <= ST_IDLE;
			else if (i2c_start)
			begin
				st <= ST_ADDR;
				bitc <= 4'h0;
				bidx <= 2'h0;
				ack_drv <= 1'b0;
				gc_arm <= 1'b0;
			end
			else if (i2c_stop)
			begin
				st <= ST_IDLE;
				ack_drv <= 1'b0;
			end
			else
			begin
				case (st)
				ST_ADDR, ST_RX:
				begin
					// bits are taken on scl rise, sda only matters while scl is high
					if (scl_rise && bitc != `DSP_BYTE_BITS)
					begin
						sh <= rx_byte;
						bitc <= bitc + 4'h1;
						if (st == ST_ADDR && bitc == 4'h0)
							strap <= syn[7:5];
					end
					else if (scl_fall && bitc == `DSP_BYTE_BITS)
					begin
						bitc <= 4'h0;
						st <= ST_ACK;
						ack_drv <= 1'b1;
						if (st == ST_ADDR)
						begin
							rw <= sh[0];
							gc <= (sh == `DSP_GC_ADDR);
							// only 7-bit codes; ten-bit headers never match
							if (!(sh[7:1] == {`DSP_I2C_PREFIX, strap}) &&
							    !(sh[7:1] == `DSP_I2C_BCAST && !sh[0]) &&
							    !(sh == `DSP_GC_ADDR))
							begin
								ack_drv <= 1'b0;
								st <= ST_IDLE;
							end
						end
						else if (gc)
							gc_arm <= (sh == `DSP_GC_RESET);
						else if (bidx == 2'h0)
						begin
							i2c_raddr <= sh[6:0];
							bidx <= 2'h1;
						end
						else if (bidx == 2'h1)
						begin
							msdb <= sh;
							bidx <= 2'h2;
						end
						else
						begin
							i2c_word <= {i2c_raddr, msdb, sh};
							i2c_wr <= 1'b1;
							bidx <= 2'h1;
						end
					end
				end
				ST_ACK:
				begin
					if (scl_rise && gc_arm)
					begin
						sw_reset_o <= 1'b1;
						gc_arm <= 1'b0;
					end
					if (scl_fall)
					begin
						ack_drv <= 1'b0;
						if (rw)
						begin
							st <= ST_TX;
							sh <= rd_data_i[15:8];
							bidx <= 2'h1;
						end
						else
							st <= ST_RX;
					end
				end
				ST_TX:
				begin
					if (scl_fall)
					begin
						if (bitc == 4'h7)
						begin
							bitc <= 4'h0;
							st <= ST_MACK;
						end
						else
						begin
							bitc <= bitc + 4'h1;
							sh <= {sh[6:0], 1'b1};
						end
					end
				end
				ST_MACK:
				begin
					if (scl_rise)
						mack_ok <= !sda;
					if (scl_fall)
					begin
						if (mack_ok)
						begin
							st <= ST_TX;
							sh <= (bidx == 2'h1) ? rd_data_i[7:0] : 8'h00;
							bidx <= 2'h2;
						end
						else
							st <= ST_IDLE;
					end
				end
				default:
					st <= ST_IDLE;
				endcase
			end
		end
	end

	// -------------------------------------------------------------
	// write staging and fifo
	// -------------------------------------------------------------
	// a staged word on a full fifo holds scl low; spi has no stall, so a further write is lost
	reg pend;
	reg [22:0] pend_word;
	wire fifo_ready;
	wire take = !pend || fifo_ready;

	always @(posedge clk_sys_i)
	begin
		if (reset_i)
		begin
			pend <= 1'b0;
			pend_word <= 23'h00_0000;
		end
		else if (take)
		begin
			pend <= spi_wr || i2c_wr;
			pend_word <= spi_wr ? {cmd_frame[22:16], cmd_frame[15:0]} : i2c_word;
		end
	end

	dsp_fifo #(
		.W(23),
		.D(FIFO_DEPTH),
		.AW(3)
	) u_fifo (
		.clk_sys_i(clk_sys_i),
		.reset_i(reset_i),
		.in_valid_i(pend),
		.in_ready_o(fifo_ready),
		.in_data_i(pend_word),
		.out_valid_o(wr_valid_o),
		.out_ready_i(wr_ready_i),
		.out_data_o({wr_addr_o, wr_data_o})
	);

	assign rd_addr_o = lock_i2c_o ? i2c_raddr : spi_raddr;
	assign scl_o = 1'b0;
	assign scl_oe_o = pend && !fifo_ready && i2c_on && (st != ST_IDLE);
	assign sda_o = 1'b0;
	assign sda_oe_o = i2c_on && (ack_drv || (st == ST_TX && !sh[7]));
endmodule // dsp_port

// >>> tb/dsp_port_assertions.sv
// checker for the dual serial host port, ports of dsp_port only
// assumes binding to dsp_port, one clock domain on clk_sys_i
`timescale 1ns/1ps
module dsp_chk (
	// watched ports
	input wire clk_sys_i,
	input wire reset_i,
	input wire spi_sel_n_i,
	input wire scl_i,
	input wire serial_out_enable_i,
	input wire wr_ready_i,
	input wire spi_sdo_oe_o,
	input wire scl_oe_o,
	input wire sda_oe_o,
	input wire wr_valid_o,
	input wire [6:0] wr_addr_o,
	input wire [15:0] wr_data_o,
	input wire sw_reset_o,
	input wire lock_spi_o,
	input wire lock_i2c_o
);
	// ---------------------------------------------
	// properties
	// ---------------------------------------------
	default clocking @(posedge clk_sys_i);
	endclocking
	default disable iff (reset_i);
	// four cycles cover the select synchroniser
	property p_oe_idle;
		spi_sel_n_i [*4] |-> !spi_sdo_oe_o;
	endproperty
	a_oe_idle: assert property (p_oe_idle) else $error("sdo driven while deselected");
	property p_oe_3w;
		!serial_out_enable_i |-> !spi_sdo_oe_o;
	endproperty
	a_oe_3w: assert property (p_oe_3w) else $error("sdo driven in three-wire mode");
	property p_swr;
		sw_reset_o |=> !sw_reset_o;
	endproperty
	a_swr: assert property (p_swr) else $error("soft reset longer than one cycle");
	property p_swr_lock;
		sw_reset_o |-> lock_i2c_o;
	endproperty
	a_swr_lock: assert property (p_swr_lock) else $error("soft reset without i2c lock");
	property p_lock_x;
		!(lock_spi_o && lock_i2c_o);
	endproperty
	a_lock_x: assert property (p_lock_x) else $error("both protocols locked");
	property p_lock_keep;
		!($fell(lock_spi_o) || $fell(lock_i2c_o));
	endproperty
	a_lock_keep: assert property (p_lock_keep) else $error("protocol lock dropped");
	property p_i2c_quiet;
		lock_spi_o |-> !sda_oe_o && !scl_oe_o;
	endproperty
	a_i2c_quiet: assert property (p_i2c_quiet) else $error("i2c pins driven under spi lock");
	property p_spi_quiet;
		lock_i2c_o |-> !spi_sdo_oe_o;
	endproperty
	a_spi_quiet: assert property (p_spi_quiet) else $error("sdo driven under i2c lock");
	property p_sda_chg;
		$changed(sda_oe_o) |-> !scl_i;
	endproperty
	a_sda_chg: assert property (p_sda_chg) else $error("sda changed while scl high");
	property p_wr_hold;
		wr_valid_o && !wr_ready_i |=> wr_valid_o && $stable(wr_addr_o) && $stable(wr_data_o);
	endproperty
	a_wr_hold: assert property (p_wr_hold) else $error("write word changed while stalled");
endmodule // dsp_chk

bind dsp_port dsp_chk u_chk (
	.clk_sys_i(clk_sys_i),
	.reset_i(reset_i),
	.spi_sel_n_i(spi_sel_n_i),
	.scl_i(scl_i),
	.serial_out_enable_i(serial_out_enable_i),
	.wr_ready_i(wr_ready_i),
	.spi_sdo_oe_o(spi_sdo_oe_o),
	.scl_oe_o(scl_oe_o),
	.sda_oe_o(sda_oe_o),
	.wr_valid_o(wr_valid_o),
	.wr_addr_o(wr_addr_o),
	.wr_data_o(wr_data_o),
	.sw_reset_o(sw_reset_o),
	.lock_spi_o(lock_spi_o),
	.lock_i2c_o(lock_i2c_o)
);

// >>> tb/dsp_spi_host.sv
// spi host model: frames of up to 48 bits, serial clock period 160 ns
// assumes sdo_i is the device serial output
`timescale 1ns/1ps
module dsp_spi_host (
	// spi wires
	output reg sclk_o,
	output reg sel_n_o,
	output reg sdi_o,
	input wire sdo_i
);
	initial
	begin
		sclk_o = 1'b0;
		sel_n_o = 1'b1;
		sdi_o = 1'b0;
	end
	// fall_cap: capture on fall when the device launches on rise
	task xfer(input [47:0] w, input integer n, input fall_cap, output [47:0] r);
		integer i;
		begin
			r = 48'h0;
			#3 sel_n_o = 1'b0;
			for (i = 0; i < n; i = i + 1)
			begin
				#80 sclk_o = 1'b1;
				sdi_o = w[47 - i];
				if (!fall_cap)
					r[47 - i] = sdo_i;
				#80 sclk_o = 1'b0;
				if (fall_cap)
					r[47 - i] = sdo_i;
			end
			#80 sel_n_o = 1'b1;
			// released line must not keep the last bit
			sdi_o = ~sdi_o;
			#100;
		end
	endtask
endmodule // dsp_spi_host

// >>> tb/testbench.sv
// self-checking bench for the dual serial host port
// assumes dsp_port, dsp_spi_host and the checker compiled before it
`timescale 1ns/1ps
`define CHK(n, e, a) begin check_count = check_count + 1; if ((e) !== (a)) begin \
	mismatches = mismatches + 1; $display("MISMATCH %s exp %h got %h", n, e, a); end end
module testbench;
	reg clk_sys_i = 1'b0;
	reg reset_i = 1'b1;
	reg scl_m = 1'b1;
	reg sda_m = 1'b1;
	reg serial_out_enable = 1'b0;
	reg edge_sel = 1'b0;
	reg wr_ready = 1'b0;
	reg ack;
	reg [47:0] r;
	reg [7:0] rb;
	integer ph = 5;
	integer mismatches = 0;
	integer check_count = 0;
	integer cyc = 0;
	integer swr_cnt = 0;
	wire sclk, sel_n, sdi, sdo, sdo_oe, scl_oe, sda_oe, wr_valid, swr, lk_spi, lk_i2c;
	wire [6:0] wr_addr;
	wire [6:0] rd_addr;
	wire [15:0] wr_data;
	wire [15:0] rd_data = {rd_addr, 9'h0ab};
	// sdo has no pull: a released line reads back inverted
	wire sdo_line = sdo_oe ? sdo : ~sdo;
	// open-drain lines with pull-ups
	wire scl = scl_m & ~scl_oe;
	wire sda = sda_m & ~sda_oe;
	// ---------------------------------------------
	// clock, timeout, instances
	// ---------------------------------------------
	always #4 clk_sys_i = ~clk_sys_i;
	always @(posedge clk_sys_i)
	begin
		cyc = cyc + 1;
		if (swr === 1'b1)
			swr_cnt = swr_cnt + 1;
		if (cyc == 60000)
		begin
			mismatches = mismatches + 1;
			summarize;
		end
	end
	dsp_spi_host u_host (.sclk_o(sclk), .sel_n_o(sel_n), .sdi_o(sdi), .sdo_i(sdo_line));
	dsp_port u_dut (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .spi_sclk_i(sclk), .spi_sel_n_i(sel_n),
		.spi_sdi_i(sdi), .spi_sdo_o(sdo), .spi_sdo_oe_o(sdo_oe), .scl_i(scl), .scl_o(), .scl_oe_o(scl_oe),
		.sda_i(sda), .sda_o(), .sda_oe_o(sda_oe), .address_strap_pin_i(3'h5), .serial_out_enable_i(serial_out_enable),
		.out_edge_select_i(edge_sel), .wr_valid_o(wr_valid), .wr_ready_i(wr_ready), .wr_addr_o(wr_addr),
		.wr_data_o(wr_data), .rd_addr_o(rd_addr), .rd_data_i(rd_data), .sw_reset_o(swr),
		.lock_spi_o(lk_spi), .lock_i2c_o(lk_i2c));
	// ---------------------------------------------
	// shared tasks
	// ---------------------------------------------
	task ck(input integer n);
		repeat (n) @(posedge clk_sys_i);
	endtask
	task wv(input integer n);
		integer i;
		begin
			@(negedge clk_sys_i);
			for (i = 0; i < n && wr_valid !== 1'b1; i = i + 1)
				@(negedge clk_sys_i);
		end
	endtask
	task pop(input [6:0] a, input [15:0] d);
		begin
			wv(900);
			`CHK("wr_addr", a, wr_addr)
			`CHK("wr_data", d, wr_data)
			@(posedge clk_sys_i);
			wr_ready <= 1'b1;
			ck(1);
			wr_ready <= 1'b0;
		end
	endtask
	task rst;
		begin
			reset_i <= 1'b1;
			ck(20);
			reset_i <= 1'b0;
			ck(5);
		end
	endtask
	task i2c_bit(input b, output s);
		begin
			sda_m <= b;
			ck(ph);
			scl_m <= 1'b1;
			ck(ph);
			@(negedge clk_sys_i);
			s = sda;
			ck(ph);
			scl_m <= 1'b0;
			ck(ph);
		end
	endtask
	task i2c_byte(input [7:0] b, output a);
		integer i;
		reg s;
		begin
			for (i = 7; i >= 0; i = i - 1)
				i2c_bit(b[i], s);
			i2c_bit(1'b1, s);
			a = ~s;
		end
	endtask
	task i2c_rd(input nak, output [7:0] d);
		integer i;
		reg s;
		begin
			for (i = 7; i >= 0; i = i - 1)
			begin
				i2c_bit(1'b1, s);
				d[i] = s;
			end
			i2c_bit(nak, s);
		end
	endtask
	task i2c_start;
		begin
			sda_m <= 1'b1;
			scl_m <= 1'b1;
			ck(ph);
			sda_m <= 1'b0;
			ck(ph);
			scl_m <= 1'b0;
			ck(ph);
		end
	endtask
	task i2c_stop;
		begin
			sda_m <= 1'b0;
			ck(ph);
			scl_m <= 1'b1;
			ck(ph);
			sda_m <= 1'b1;
			ck(10);
		end
	endtask
	// ---------------------------------------------
	// scenarios
	// ---------------------------------------------
	task t_fill;
		integer k;
		begin
			for (k = 0; k < 10; k = k + 1)
				u_host.xfer({1'b0, 7'h10 + k[6:0], 16'h5a00 + k[15:0], 24'h0}, 24, 1'b0, r);
			for (k = 0; k < 8; k = k + 1)
				pop(7'h10 + k[6:0], 16'h5a00 + k[15:0]);
			// a staged ninth word may follow
			@(posedge clk_sys_i);
			wr_ready <= 1'b1;
			ck(8);
			wr_ready <= 1'b0;
			wv(10);
			`CHK("drained", 1'b0, wr_valid)
			`CHK("lock_spi", 1'b1, lk_spi)
		end
	endtask
	task t_short;
		begin
			u_host.xfer(48'h0012_3400_0000, 23, 1'b0, r);
			wv(40);
			`CHK("short", 1'b0, wr_valid)
			u_host.xfer({24'h03_1234, 24'hff_ffff}, 30, 1'b0, r);
			pop(7'h03, 16'h1234);
		end
	endtask
	task t_read;
		integer e;
		begin
			serial_out_enable <= 1'b1;
			for (e = 0; e < 2; e = e + 1)
			begin
				edge_sel <= e[0];
				ck(2);
				u_host.xfer({1'b1, 7'h2a, 16'h0, 24'h0}, 24, e[0], r);
				u_host.xfer({1'b1, 7'h11, 16'h0, 24'h0}, 24, e[0], r);
				`CHK("rd_word", {1'b1, 7'h2a, 7'h2a, 9'h0ab}, r[47:24])
			end
			edge_sel <= 1'b0;
		end
	endtask
	task t_echo;
		begin
			u_host.xfer({24'h45_beef, 24'h0}, 24, 1'b0, r);
			u_host.xfer({24'h80_0000, 24'h0}, 24, 1'b0, r);
			`CHK("echo", 24'h45_beef, r[47:24])
			pop(7'h45, 16'hbeef);
			u_host.xfer({24'h0a_1111, 24'h0b_2222}, 48, 1'b0, r);
			pop(7'h0b, 16'h2222);
			u_host.xfer({24'h0c_3333, 24'h0}, 30, 1'b0, r);
			wv(40);
			`CHK("daisy_odd", 1'b0, wr_valid)
			serial_out_enable <= 1'b0;
		end
	endtask
	task t_i2c;
		begin
			rst;
			i2c_start;
			i2c_byte(8'h9a, ack);
			`CHK("ack_addr", 1'b1, ack)
			i2c_byte(8'h05, ack);
			i2c_byte(8'h12, ack);
			i2c_byte(8'h34, ack);
			`CHK("ack_data", 1'b1, ack)
			i2c_stop;
			pop(7'h05, 16'h1234);
			i2c_start;
			i2c_byte(8'h98, ack);
			`CHK("ack_other", 1'b0, ack)
			i2c_stop;
			i2c_start;
			i2c_byte(8'hf0, ack);
			`CHK("ack_10bit", 1'b0, ack)
			i2c_stop;
			// read back at a bit rate near fast-plus
			ph = 32;
			i2c_start;
			i2c_byte(8'h9a, ack);
			i2c_byte(8'h07, ack);
			i2c_start;
			i2c_byte(8'h9b, ack);
			`CHK("ack_rd", 1'b1, ack)
			i2c_rd(1'b0, rb);
			`CHK("rd_msdb", 8'h0e, rb)
			i2c_rd(1'b1, rb);
			`CHK("rd_lsdb", 8'hab, rb)
			i2c_stop;
			ph = 5;
			i2c_start;
			i2c_byte(8'h00, ack);
			i2c_byte(8'h06, ack);
			i2c_stop;
			`CHK("sw_reset", 1, swr_cnt)
			`CHK("lock_i2c", 1'b1, lk_i2c)
			serial_out_enable <= 1'b1;
			u_host.xfer({24'h01_5555, 24'h0}, 24, 1'b0, r);
			wv(40);
			`CHK("spi_ignored", 1'b0, wr_valid)
			`CHK("lock_spi_off", 1'b0, lk_spi)
		end
	endtask
	task summarize;
		begin
			if (mismatches == 0 && check_count > 0)
				$display("*** PASS ***");
			else
				$display("*** FAIL ***");
			$finish;
		end
	endtask
	initial
	begin
		rst;
		t_fill;
		t_short;
		t_read;
		t_echo;
		t_i2c;
		summarize;
	end
endmodule // testbench
